// ==== core/dcsi_map.vh ====
// Purpose: Constants for the daisy-chain serial input path
// Assumes: Included by bare name from core design files
// Notes: Definitions only
`ifndef DCSI_MAP_VH
`define DCSI_MAP_VH
`define DCSI_WORD_BITS 16
`define DCSI_CNT_BITS 5
`define DCSI_MSB 15
`define DCSI_FIFO_DEPTH 16
`define DCSI_FIFO_AW 4
`define DCSI_SHIFT_RST 16'h0000
`define DCSI_DAC_RST 16'h0000
`define DCSI_CNT_RST 5'h00
`define DCSI_ST_IDLE 3'h1
`define DCSI_ST_SHIFT 3'h2
`define DCSI_ST_HOLD 3'h4
`endif

// ==== core/dcsi_sync.v ====
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to clk_i
// Notes: First stage is read only by the second
`timescale 1ns/1ps
module dcsi_sync #(
   parameter WIDTH = 4,
   parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
   input wire clk_i,
   input wire rst_n_i,
   input wire [WIDTH-1:0] async_i,
   output wire [WIDTH-1:0] sync_o
);
   reg [WIDTH-1:0] meta_ff;
   reg [WIDTH-1:0] sync_ff;

   // Plain double-register stage, reset to idle pin levels
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_ff <= RST_VAL;
         sync_ff <= RST_VAL;
      end else begin
         meta_ff <= async_i;
         sync_ff <= meta_ff;
      end
   end

   assign sync_o = sync_ff;
endmodule

// ==== core/dcsi_fifo.v ====
// Purpose: Small synchronous FIFO for latched words
// Assumes: Single clock, depth a power of two
// Notes: Read data comes from a register
`timescale 1ns/1ps
module dcsi_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire clk_i,
   input wire rst_n_i,
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [WIDTH-1:0] in_data_i,
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [WIDTH-1:0] out_data_o
);
   reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
   reg [AW:0] wr_ptr_ff;
   reg [AW:0] rd_ptr_ff;
   reg [WIDTH-1:0] rd_data_ff;
   reg rd_valid_ff;
   wire full;
   wire empty;
   wire [AW:0] used;
   wire do_wr;
   wire do_rd;

   // The output register holds a word too, so count it against the depth
   assign used = wr_ptr_ff - rd_ptr_ff;
   assign full = used[AW] || ((used == DEPTH - 1) && rd_valid_ff);
   assign empty = (wr_ptr_ff == rd_ptr_ff);
   assign in_ready_o = !full;
   assign do_wr = in_valid_i && !full;
   // Prefetch into output register when it is free or being drained
   assign do_rd = !empty && (!rd_valid_ff || out_ready_i);
   assign out_valid_o = rd_valid_ff;
   assign out_data_o = rd_data_ff;

   // Storage array, no reset needed on data
   always @(posedge clk_i) begin
      if (do_wr) begin
         mem_ff[wr_ptr_ff[AW-1:0]] <= in_data_i;
      end
   end

   // Pointers and registered read port
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr_ff <= {(AW+1){1'b0}};
         rd_ptr_ff <= {(AW+1){1'b0}};
         rd_data_ff <= {WIDTH{1'b0}};
         rd_valid_ff <= 1'b0;
      end else begin
         if (do_wr) begin
            wr_ptr_ff <= wr_ptr_ff + 1'b1;
         end
         if (do_rd) begin
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
            rd_data_ff <= mem_ff[rd_ptr_ff[AW-1:0]];
            rd_valid_ff <= 1'b1;
         end else if (out_ready_i) begin
            rd_valid_ff <= 1'b0;
         end
      end
   end
endmodule

// ==== core/dcsi_core.v ====
// Purpose: Daisy-chain serial input path with serial pass-through output
// Assumes: Shift clock, data, frame select, load strobe and mode pin are
//          asynchronous pins sampled by clk_i (shift clock well below clk_i/4)
// Notes: Latched words queue in a FIFO before the load strobe moves them
//
// Overview of operation
// - Chain mode pin high selects daisy chain, low selects standalone.
// - Chain mode removes the fixed sixteen-clock gating of the shift clock.
// - In chain mode every shift clock rising edge shifts while frame low.
// - Beyond sixteen pulses, bits leaving the register appear on serial out.
// - In chain mode serial out changes after shift clock falling edge, held a full period.
// - Frame select high ends transfer; no further bits enter the register.
// - Word latched on frame select rising edge in both modes.
// - Shared load strobe moves the oldest queued word into DAC register together.
// - Serial out gives readback or feeds next device serial input.
// - First bit received is the most significant bit.
// - Serial input sampled on shift clock rising edge.
`timescale 1ns/1ps
`include "dcsi_map.vh"
module dcsi_core #(
   parameter WIDTH = `DCSI_WORD_BITS,
   parameter DEPTH = `DCSI_FIFO_DEPTH,
   parameter AW = `DCSI_FIFO_AW
) (
   input wire clk_i,
   input wire rst_n_i,
   input wire shift_clk_i,
   input wire serial_data_in_i,
   input wire frame_select_n_i,
   input wire load_outputs_n_i,
   input wire chain_enable_pin_i,
   input wire dac_ready_i,
   output wire chain_serial_out_o,
   output wire [WIDTH-1:0] input_reg_o,
   output wire [WIDTH-1:0] dac_reg_o,
   output wire dac_update_o,
   output wire word_pending_o,
   output wire frame_overrun_o,
   output wire chain_mode_o
);
   wire [3:0] pins_sync;
   wire sclk_s;
   wire sdin_s;
   wire frame_n_s;
   wire load_outputs_n_n_s;
   reg chain_en_ff;
   reg sclk_d_ff;
   reg frame_d_ff;
   reg load_outputs_n_d_ff;
   reg [WIDTH-1:0] shift_ff;
   reg [`DCSI_CNT_BITS-1:0] cnt_ff;
   reg [2:0] state_ff;
   reg [2:0] nxt_state;
   reg sdo_ff;
   wire mode_s;
   wire [WIDTH-1:0] nxt_shift;
   genvar g;
   reg [WIDTH-1:0] in_reg_ff;
   reg [WIDTH-1:0] dac_ff;
   reg upd_ff;
   reg overrun_ff;
   wire sclk_rise;
   wire sclk_fall;
   wire frame_rise;
   wire frame_fall;
   wire load_outputs_n_fall;
   wire gate_open;
   wire do_shift;
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [WIDTH-1:0] fifo_out_data;
   wire fifo_take;

   // Pins idle high for frame, load strobe and link clock
   // Resetting to idle levels avoids a false edge right after reset
   dcsi_sync #(
      .WIDTH(4),
      .RST_VAL(4'hD)
   ) u_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .async_i({frame_select_n_i, load_outputs_n_i, serial_data_in_i, shift_clk_i}),
      .sync_o(pins_sync)
   );

   assign sclk_s = pins_sync[0];
   assign sdin_s = pins_sync[1];
   assign load_outputs_n_n_s = pins_sync[2];
   assign frame_n_s = pins_sync[3];

   // Mode strap is a pin too, so it gets its own two flops
   // before the frame-gated sample below
   dcsi_sync #(
      .WIDTH(1),
      .RST_VAL(1'b0)
   ) u_mode_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .async_i(chain_enable_pin_i),
      .sync_o(mode_s)
   );

   // Edge history of synchronised pins
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sclk_d_ff <= 1'b1;
         frame_d_ff <= 1'b1;
         load_outputs_n_d_ff <= 1'b1;
      end else begin
         sclk_d_ff <= sclk_s;
         frame_d_ff <= frame_n_s;
         load_outputs_n_d_ff <= load_outputs_n_n_s;
      end
   end

   // Single-cycle edge pulses; the link must stay well below clk_i/4
   // or an edge can be lost between two samples
   assign sclk_rise = sclk_s && !sclk_d_ff;
   assign sclk_fall = !sclk_s && sclk_d_ff;
   assign frame_rise = frame_n_s && !frame_d_ff;
   assign frame_fall = !frame_n_s && frame_d_ff;
   assign load_outputs_n_fall = !load_outputs_n_n_s && load_outputs_n_d_ff;

   // Mode pin is a static strap; sample it only between frames so a
   // change mid-frame cannot corrupt the bit count
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         chain_en_ff <= 1'b0;
      end else if (frame_n_s) begin
         chain_en_ff <= mode_s;
      end
   end

   // Frame state machine
   // Hold parks a standalone frame after sixteen bits until the
   // frame select rises, so extra pulses are simply ignored
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         `DCSI_ST_IDLE: begin
            if (frame_fall) begin
               nxt_state = `DCSI_ST_SHIFT;
            end
         end
         `DCSI_ST_SHIFT: begin
            if (frame_rise) begin
               nxt_state = `DCSI_ST_IDLE;
            end else if (!gate_open) begin
               nxt_state = `DCSI_ST_HOLD;
            end
         end
         `DCSI_ST_HOLD: begin
            if (frame_rise) begin
               nxt_state = `DCSI_ST_IDLE;
            end
         end
         default: begin
            nxt_state = `DCSI_ST_IDLE;
         end
      endcase
   end

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_ff <= `DCSI_ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Standalone gates after sixteen bits; chain mode never gates
   assign gate_open = chain_en_ff || (cnt_ff < `DCSI_WORD_BITS);
   // Shift only on rising edge while frame is low
   assign do_shift = sclk_rise && !frame_n_s && gate_open && (state_ff != `DCSI_ST_HOLD);

   // One stage per bit: stage zero takes the pin, the rest take
   // their neighbour, so the first bit in ends up at the top
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : g_stage
         if (g == 0) begin : g_first
            assign nxt_shift[g] = sdin_s;
         end else begin : g_rest
            assign nxt_shift[g] = shift_ff[g-1];
         end
      end
   endgenerate

   // Shift register and pulse count; the count saturates so a long
   // free-running burst cannot wrap it back below sixteen
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         shift_ff <= `DCSI_SHIFT_RST;
         cnt_ff <= `DCSI_CNT_RST;
      end else if (frame_fall) begin
         cnt_ff <= `DCSI_CNT_RST;
      end else if (do_shift) begin
         shift_ff <= nxt_shift;
         if (cnt_ff != {`DCSI_CNT_BITS{1'b1}}) begin
            cnt_ff <= cnt_ff + 1'b1;
         end
      end
   end

   // Serial out updates only after a falling edge, so it is stable
   // across the next rising edge where the next device samples it.
   // It shows the top stage, so a frame's first bit is ready for the
   // far device's seventeenth rising edge; quiet in standalone
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sdo_ff <= 1'b0;
      end else if (!chain_en_ff) begin
         sdo_ff <= 1'b0;
      end else if (sclk_fall) begin
         sdo_ff <= shift_ff[WIDTH-1];
      end
   end

   // Latch the word at frame end in either mode; queue it if room.
   // A full queue still updates the visible input register, only
   // the queued copy is lost and flagged until the next frame
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         in_reg_ff <= `DCSI_DAC_RST;
         overrun_ff <= 1'b0;
      end else begin
         if (frame_rise) begin
            in_reg_ff <= shift_ff;
         end
         if (frame_rise && !fifo_in_ready) begin
            overrun_ff <= 1'b1;
         end else if (frame_fall) begin
            overrun_ff <= 1'b0;
         end
      end
   end

   // Load strobe moves the oldest queued word; dac_ready_i can stall
   // Only the falling edge acts, so a strobe held low moves one word
   assign fifo_take = load_outputs_n_fall && dac_ready_i;

   // DAC register and its one-cycle update pulse

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dac_ff <= `DCSI_DAC_RST;
         upd_ff <= 1'b0;
      end else begin
         upd_ff <= 1'b0;
         if (fifo_take && fifo_out_valid) begin
            dac_ff <= fifo_out_data;
            upd_ff <= 1'b1;
         end
      end
   end

   // Queue between frame ends and load strobes; trades area for
   // letting the host send several frames before one update
   dcsi_fifo #(
      .WIDTH(WIDTH),
      .DEPTH(DEPTH),
      .AW(AW)
   ) u_fifo (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .in_valid_i(frame_rise),
      .in_ready_o(fifo_in_ready),
      .in_data_i(shift_ff),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_take),
      .out_data_o(fifo_out_data)
   );

   // All outputs come straight from flip-flops
   assign chain_serial_out_o = sdo_ff;
   assign input_reg_o = in_reg_ff;
   assign dac_reg_o = dac_ff;
   assign dac_update_o = upd_ff;
   assign word_pending_o = fifo_out_valid;
   assign frame_overrun_o = overrun_ff;
   assign chain_mode_o = chain_en_ff;
endmodule

// ==== tb/dcsi_core_checker.sv ====
// Purpose: Port assertions for the serial input core
// Assumes: Bound to every dcsi_core
// Notes: Figures follow the two-flop pin path
`timescale 1ns/1ps
module dcsi_core_checker #(
   parameter WIDTH = 16
) (
   input wire clk_i,
   input wire rst_n_i,
   input wire shift_clk_i,
   input wire frame_select_n_i,
   input wire load_outputs_n_i,
   input wire chain_enable_pin_i,
   input wire chain_serial_out_o,
   input wire [WIDTH-1:0] input_reg_o,
   input wire [WIDTH-1:0] dac_reg_o,
   input wire dac_update_o,
   input wire word_pending_o,
   input wire chain_mode_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // Strap settles only while frame is high
   a_mode_chain_on: assert property ((frame_select_n_i && chain_enable_pin_i)[*6] |-> chain_mode_o)
      else $error("chain mode missed");
   a_mode_alone_on: assert property ((frame_select_n_i && !chain_enable_pin_i)[*6] |-> !chain_mode_o)
      else $error("standalone missed");
   a_alone_out_quiet: assert property ((!chain_mode_o)[*6] |-> !chain_serial_out_o)
      else $error("serial out busy in standalone");
   // In chain mode serial out moves only while the link clock is low
   a_out_after_fall: assert property ($changed(chain_serial_out_o) |-> !$past(shift_clk_i, 2) || !chain_mode_o)
      else $error("serial out moved off a fall");
   a_latch_on_rise: assert property ($changed(input_reg_o) |-> $past(frame_select_n_i, 2))
      else $error("word latched inside frame");
   a_pending_on_rise: assert property ($rose(word_pending_o) |-> $past(frame_select_n_i, 2))
      else $error("word queued inside frame");
   // Load strobe, queued word, single pulse
   a_update_after_load: assert property (dac_update_o |-> !$past(load_outputs_n_i, 3))
      else $error("update without strobe");
   a_update_needs_word: assert property (dac_update_o |-> $past(word_pending_o))
      else $error("update from empty queue");
   a_update_one_cycle: assert property (dac_update_o |=> !dac_update_o)
      else $error("update pulse too long");
   a_dac_with_update: assert property ($changed(dac_reg_o) |-> dac_update_o)
      else $error("dac changed silently");
endmodule
bind dcsi_core dcsi_core_checker #(.WIDTH(WIDTH)) dcsi_core_checker_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
   .shift_clk_i(shift_clk_i), .frame_select_n_i(frame_select_n_i), .load_outputs_n_i(load_outputs_n_i),
   .chain_enable_pin_i(chain_enable_pin_i), .chain_serial_out_o(chain_serial_out_o), .input_reg_o(input_reg_o),
   .dac_reg_o(dac_reg_o), .dac_update_o(dac_update_o), .word_pending_o(word_pending_o), .chain_mode_o(chain_mode_o));

// ==== tb/dcsi_host_model.sv ====
// Purpose: Host end of the serial link
// Assumes: Link clock idles high between frames
// Notes: Captures serial out once per pulse
`timescale 1ns/1ps
module dcsi_host_model (
   input wire chain_serial_out_i,
   output reg shift_clk_o,
   output reg serial_data_o,
   output reg frame_select_n_o
);
   reg [63:0] rx_bits;
   // Idle levels
   initial begin
      shift_clk_o = 1'b1;
      serial_data_o = 1'b0;
      frame_select_n_o = 1'b1;
      rx_bits = 64'h0;
   end
   // Burst of n pulses, MSB first; frame low only when framed
   task send(input [63:0] bits, input integer n, input framed);
      integer k;
      begin
         #11 frame_select_n_o = !framed;
         #100;
         for (k = n - 1; k >= 0; k = k - 1) begin
            shift_clk_o = 1'b0;
            serial_data_o = bits[k];
            #100 shift_clk_o = 1'b1;
            #50 rx_bits = {rx_bits[62:0], chain_serial_out_i};
            #50;
         end
         #100 frame_select_n_o = 1'b1;
         // Released data line must not keep its last value
         serial_data_o = !serial_data_o;
         #100;
      end
   endtask
endmodule

// ==== tb/dcsi_core_test.sv ====
// Purpose: Random and corner frames through the serial input core
// Assumes: Host model drives the link pins
// Notes: Expected words come from the bench's own sums
`timescale 1ns/1ps
module dcsi_core_test;
   reg clk_i, rst_n_i, load_outputs_n_i, chain_enable_pin_i, dac_ready_i, seen;
   wire sclk, sdin, frame_n, sout, upd, pend, ovr, mode;
   wire [15:0] in_reg, dac_reg;
   integer bad_count, n_tests, i;
   reg [31:0] rnd;
   reg [15:0] q [0:16];
   dcsi_core dcsi_core_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .shift_clk_i(sclk), .serial_data_in_i(sdin),
      .frame_select_n_i(frame_n), .load_outputs_n_i(load_outputs_n_i), .chain_enable_pin_i(chain_enable_pin_i),
      .dac_ready_i(dac_ready_i), .chain_serial_out_o(sout), .input_reg_o(in_reg), .dac_reg_o(dac_reg),
      .dac_update_o(upd), .word_pending_o(pend), .frame_overrun_o(ovr), .chain_mode_o(mode));
   dcsi_host_model dcsi_host_model_inst (.chain_serial_out_i(sout), .shift_clk_o(sclk), .serial_data_o(sdin),
      .frame_select_n_o(frame_n));
   // 40 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Standalone gating keeps the first sixteen bits
   function [15:0] first_word(input [63:0] b, input integer n);
      first_word = b >> (n - 16);
   endfunction
   task check(input [63:0] got, input [63:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task gap;
      begin
         repeat (8) @(posedge clk_i);
         #2;
      end
   endtask
   // Strobe held ten cycles; reports any update pulse
   task load(output reg s);
      begin
         s = 1'b0;
         load_outputs_n_i = 1'b0;
         repeat (10) begin
            @(posedge clk_i);
            #2 if (upd === 1'b1) s = 1'b1;
         end
         load_outputs_n_i = 1'b1;
         gap;
      end
   endtask
   task final_report;
      begin
         $display("checks %0d mismatches %0d", n_tests, bad_count);
         if (bad_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
         end else begin
            $display("SIMULATION FAILED");
         end
         $finish;
      end
   endtask
   // Cut a hang short
   initial begin
      #400000;
      bad_count = bad_count + 1;
      final_report;
   end
   // Main sequence
   initial begin
      bad_count = 0;
      n_tests = 0;
      rnd = 32'h00017D21;
      rst_n_i = 1'b0;
      load_outputs_n_i = 1'b1;
      chain_enable_pin_i = 1'b1;
      dac_ready_i = 1'b1;
      repeat (16) @(posedge clk_i);
      #2 rst_n_i = 1'b1;
      gap;
      // Two chained words; far word returns on serial out
      rnd = lfsr(rnd);
      dcsi_host_model_inst.send({32'h0, rnd}, 32, 1'b1);
      gap;
      check(in_reg, rnd[15:0]);
      check(dcsi_host_model_inst.rx_bits[15:0], rnd[31:16]);
      check({mode, pend}, 2'h3);
      // Stray pulses with frame high must not shift
      dcsi_host_model_inst.send(64'hFF, 8, 1'b0);
      dcsi_host_model_inst.send(64'hA5, 8, 1'b1);
      gap;
      check(in_reg, {rnd[7:0], 8'hA5});
      load(seen);
      check({seen, dac_reg}, {1'b1, rnd[15:0]});
      load(seen);
      check({seen, dac_reg}, {1'b1, rnd[7:0], 8'hA5});
      load(seen);
      check({seen, pend}, 2'h0);
      // Standalone frame of 32 pulses
      chain_enable_pin_i = 1'b0;
      gap;
      rnd = lfsr(rnd);
      dcsi_host_model_inst.send({32'h0, rnd}, 32, 1'b1);
      gap;
      q[0] = first_word({32'h0, rnd}, 32);
      check({mode, dcsi_host_model_inst.rx_bits[31:0]}, 33'h0);
      check(in_reg, q[0]);
      // Fill the queue until a frame is dropped
      for (i = 1; i < 17; i = i + 1) begin
         rnd = lfsr(rnd);
         q[i] = rnd[15:0];
         dcsi_host_model_inst.send({48'h0, q[i]}, 16, 1'b1);
         gap;
         check({ovr, in_reg}, {i == 16, q[i]});
      end
      // Stalled far side ignores the strobe
      dac_ready_i = 1'b0;
      load(seen);
      check(seen, 1'b0);
      dac_ready_i = 1'b1;
      for (i = 0; i < 16; i = i + 1) begin
         load(seen);
         check({seen, dac_reg}, {1'b1, q[i]});
      end
      check(pend, 1'b0);
      final_report;
   end
endmodule
